// ===== stl_pkg.sv
package stl_pkg;
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned SECOND_NS = 1000000000;
   localparam int unsigned TICK_CYCLES_DEF = SECOND_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_W = 25;
   localparam int unsigned INTERVAL_MIN_S = 1;
   localparam int unsigned INTERVAL_MAX_H = 9;
   localparam int unsigned SEC_PER_HOUR = 3600;
   localparam logic [15:0] INTERVAL_MIN = 16'(INTERVAL_MIN_S);
   localparam logic [15:0] INTERVAL_MAX = 16'(INTERVAL_MAX_H * SEC_PER_HOUR);
   // Widths
   localparam int unsigned ADC_W = 10;
   localparam int unsigned RTC_W = 32;
   localparam int unsigned PWD_W = 32;
   localparam int unsigned PWD_HALF = 16;
   localparam int unsigned NUM_AREAS = 3;
   localparam int unsigned NUM_CH = 4;
   // Nonvolatile banks, sizes in bits
   localparam int unsigned BANK_SYSTEM_BITS = 512;
   localparam int unsigned BANK_RESERVED_BITS = 64;
   localparam int unsigned BANK_IDENT_BITS = 144;
   localparam int unsigned BANK_TAGID_BITS = 80;
   localparam int unsigned BANK_USER_BITS = 8416;
   localparam logic [2:0] BANK_SYSTEM = 3'h0;
   localparam logic [2:0] BANK_RESERVED = 3'h1;
   localparam logic [2:0] BANK_IDENT = 3'h2;
   localparam logic [2:0] BANK_TAGID = 3'h3;
   localparam logic [2:0] BANK_USER = 3'h4;
   // Password areas
   localparam logic [1:0] AREA_SYSTEM = 2'h0;
   localparam logic [1:0] AREA_APP = 2'h1;
   localparam logic [1:0] AREA_MEAS = 2'h2;
   // Converter channels
   localparam logic [1:0] CH_TEMP = 2'h0;
   localparam logic [1:0] CH_FIRST_SENSOR_INPUT = 2'h1;
   localparam logic [1:0] CH_SECOND_SENSOR_INPUT = 2'h2;
   localparam logic [1:0] CH_BAT = 2'h3;
   // Event source select and recorded source
   localparam logic [1:0] SEL_FIRST = 2'h1;
   localparam logic [1:0] SEL_SECOND = 2'h2;
   localparam logic [1:0] SEL_BOTH = 2'h3;
   // Auto-range
   localparam logic [9:0] RANGE_HI = 10'h3F0;
   localparam logic [9:0] RANGE_LO = 10'h00F;
   localparam logic [1:0] RANGE_TOP = 2'h3;
   localparam logic [1:0] RANGE_RESET = 2'h0;
   // Link rates in kbit/s
   localparam logic [9:0] FWD_MIN_KBPS = 10'h028;
   localparam logic [9:0] FWD_MAX_KBPS = 10'h0A0;
   localparam logic [9:0] RTN_MIN_KBPS = 10'h005;
   localparam logic [9:0] RTN_MAX_KBPS = 10'h280;
   // Shelf life decrement per second
   localparam logic [31:0] SHELF_STEP_COOL = 32'h00000001;
   localparam logic [31:0] SHELF_STEP_WARM = 32'h00000002;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_CONV = 2'b10,
      ST_WRITE = 2'b11
   } stl_state_t;
endpackage

// ===== stl_access_check.sv
`timescale 1ns/1ps
module stl_access_check
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [2:0] acc_bank,
   input wire logic [1:0] acc_area,
   input wire logic acc_write,
   input wire logic acc_spi,
   input wire logic acc_custom,
   input wire logic [stl_pkg::PWD_W-1:0] acc_pwd,
   input wire logic [stl_pkg::NUM_AREAS*stl_pkg::PWD_W-1:0] pwd_table,
   output logic acc_grant
);
   import stl_pkg::*;

   logic [NUM_AREAS-1:0] rw_ok;
   logic [NUM_AREAS-1:0] w_ok;
   logic [1:0] area;
   logic pwd_ok;

   // Zero half means that half is unprotected
   genvar g;
   generate
      for (g = 0; g < NUM_AREAS; g = g + 1)
      begin : g_area
         logic [PWD_HALF-1:0] hi;
         logic [PWD_HALF-1:0] lo;
         assign hi = pwd_table[g*PWD_W+PWD_HALF +: PWD_HALF];
         assign lo = pwd_table[g*PWD_W +: PWD_HALF];
         assign rw_ok[g] = (hi == '0) || (acc_pwd[PWD_W-1:PWD_HALF] == hi);
         assign w_ok[g] = rw_ok[g] && ((lo == '0) || (acc_pwd[PWD_HALF-1:0] == lo));
      end
   endgenerate

   always_comb
   begin
      area = (acc_bank == BANK_SYSTEM) ? AREA_SYSTEM : acc_area;
      if (area > AREA_MEAS)
      begin
         area = AREA_MEAS;
      end
      pwd_ok = acc_write ? w_ok[area] : rw_ok[area];
      if (acc_bank == BANK_TAGID && acc_write)
      begin
         acc_grant = 1'b0;
      end
      else if (acc_spi)
      begin
         acc_grant = 1'b1;
      end
      else if (acc_bank == BANK_SYSTEM && !acc_custom)
      begin
         acc_grant = 1'b0;
      end
      else if (acc_bank == BANK_USER || acc_bank == BANK_SYSTEM)
      begin
         acc_grant = pwd_ok;
      end
      else
      begin
         acc_grant = 1'b1;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   a_tid_locked: assert property (acc_bank == BANK_TAGID && acc_write |-> !acc_grant)
      else $error("tag identifier write granted");
   a_spi_open: assert property (acc_spi && !(acc_bank == BANK_TAGID && acc_write) |-> acc_grant)
      else $error("spi access blocked");
   a_system_std: assert property (!acc_spi && acc_bank == BANK_SYSTEM && !acc_custom |-> !acc_grant)
      else $error("system bank open to standard command");
endmodule

// ===== stl_core.sv
`timescale 1ns/1ps
// Contract
// - Real-time clock starts only on start-log, counting from the carried start time.
// - Logging interval programmable from one second to nine hours, measuring each interval.
// - One 10-bit converter with selectable references shared by temp, externals, battery.
// - Event mode logs on an external input edge instead of the interval timer.
// - Event source is first, second or both inputs; first wins when both fire.
// - Event triggers only the conversions the application selected.
// - Each event entry stores sensor value with the 32-bit clock value.
// - Three 32-bit passwords guard the three memory areas for reader access.
// - Lower password half gates writes, upper half gates reads and writes.
// - Battery classified 3V or 1.5V at power-up and the type is kept until a check retrigger reclassifies it.
// - Battery supply by default; field power only without battery or when drained.
// - Shelf life counted down dynamically; alarm output raised at expiry.
// - Memory is five banks: system, reserved, identifier, tag identifier, user.
// - Standard reader reads and writes of the system bank are refused.
// - Tag identifier bank is locked; later writes are rejected.
// - Reader-to-tag rates from 40 to 160 kbit/s are accepted.
// - Tag-to-reader rates from 5 to 640 kbit/s are supported.
// - Host port can initialise, configure and start or stop logging.
// - External front end gives auto-ranging and a threshold interrupt.
// - After a log event the core returns to active with the clock running.
// - Passwords apply to the radio side only; host port access is blocked only for tag identifier writes.
module stl_core
#(
   parameter int unsigned TICK_CYCLES = stl_pkg::TICK_CYCLES_DEF
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic rf_start_log,
   input wire logic spi_start_log,
   input wire logic rf_stop_log,
   input wire logic spi_stop_log,
   input wire logic [stl_pkg::RTC_W-1:0] start_time,
   input wire logic event_mode,
   input wire logic [1:0] irq_src_sel,
   input wire logic [stl_pkg::NUM_CH-1:0] irq_meas_sel,
   input wire logic [stl_pkg::NUM_CH-1:0] timed_meas_sel,
   input wire logic [15:0] interval_sec,
   input wire logic [2*stl_pkg::NUM_CH-1:0] ref_cfg,
   input wire logic first_sensor_input,
   input wire logic second_sensor_input,
   output logic adc_start,
   output logic [1:0] adc_channel,
   output logic [1:0] adc_ref,
   input wire logic adc_done,
   input wire logic [stl_pkg::ADC_W-1:0] adc_data,
   output logic [1:0] ext_range,
   input wire logic [stl_pkg::ADC_W-1:0] ext_thresh,
   output logic ext_thresh_hit,
   output logic log_wr_valid,
   input wire logic log_wr_ready,
   output logic [1:0] log_wr_channel,
   output logic [stl_pkg::ADC_W-1:0] log_wr_value,
   output logic [stl_pkg::RTC_W-1:0] log_wr_time,
   output logic log_wr_event,
   output logic [1:0] log_wr_source,
   output logic rtc_running,
   output logic [stl_pkg::RTC_W-1:0] rtc_time,
   output logic logging_busy,
   input wire logic bat_check_retrigger,
   input wire logic bat_level_high,
   input wire logic bat_present,
   input wire logic bat_drained,
   output logic bat_is_3v,
   output logic supply_from_field,
   input wire logic shelf_load,
   input wire logic [31:0] shelf_life_init,
   input wire logic [stl_pkg::ADC_W-1:0] shelf_ref_temp,
   output logic [31:0] shelf_remaining,
   output logic shelf_alarm,
   input wire logic [9:0] fwd_rate_kbps,
   input wire logic [9:0] rtn_rate_kbps,
   output logic fwd_rate_ok,
   output logic rtn_rate_ok,
   input wire logic pwd_load,
   input wire logic [1:0] pwd_load_area,
   input wire logic [stl_pkg::PWD_W-1:0] pwd_load_value,
   input wire logic [2:0] acc_bank,
   input wire logic [1:0] acc_area,
   input wire logic acc_write,
   input wire logic acc_spi,
   input wire logic acc_custom,
   input wire logic [stl_pkg::PWD_W-1:0] acc_pwd,
   output logic acc_grant
);
   import stl_pkg::*;

   function automatic logic [1:0] first_chan(input logic [NUM_CH-1:0] m);
      logic [1:0] c;
      c = CH_TEMP;
      for (int i = NUM_CH - 1; i >= 0; i--)
      begin
         if (m[i])
         begin
            c = 2'(i);
         end
      end
      return c;
   endfunction

   // Timebase, clock and interval
   logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
   logic [15:0] sec_cnt, next_sec_cnt;
   logic [RTC_W-1:0] next_rtc_time;
   logic next_rtc_running;
   logic tick, start_cmd, stop_cmd, timed_trig;
   logic [15:0] ivl;

   always_comb
   begin
      start_cmd = rf_start_log | spi_start_log;
      stop_cmd = rf_stop_log | spi_stop_log;
      tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
      next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
      ivl = interval_sec;
      if (ivl < INTERVAL_MIN)
      begin
         ivl = INTERVAL_MIN;
      end
      else if (ivl > INTERVAL_MAX)
      begin
         ivl = INTERVAL_MAX;
      end
      next_rtc_time = rtc_time;
      next_rtc_running = rtc_running;
      next_sec_cnt = sec_cnt;
      timed_trig = 1'b0;
      if (stop_cmd)
      begin
         next_rtc_running = 1'b0;
      end
      else if (start_cmd)
      begin
         next_rtc_running = 1'b1;
         next_rtc_time = start_time;
         next_sec_cnt = '0;
         next_tick_cnt = '0;
      end
      else if (rtc_running && tick)
      begin
         next_rtc_time = rtc_time + 1'b1;
         if (!event_mode)
         begin
            if (sec_cnt >= ivl - 1'b1)
            begin
               next_sec_cnt = '0;
               timed_trig = 1'b1;
            end
            else
            begin
               next_sec_cnt = sec_cnt + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         tick_cnt <= '0;
         sec_cnt <= '0;
         rtc_time <= '0;
         rtc_running <= 1'b0;
      end
      else
      begin
         tick_cnt <= next_tick_cnt;
         sec_cnt <= next_sec_cnt;
         rtc_time <= next_rtc_time;
         rtc_running <= next_rtc_running;
      end
   end

   // Event detection, pending triggers and log sequencer
   stl_state_t state, next_state;
   logic in1_d, in2_d, pend_timed, pend_event, next_pend_timed, next_pend_event;
   logic [1:0] pend_src, next_pend_src;
   logic [NUM_CH-1:0] mask, next_mask, rest;
   logic [RTC_W-1:0] next_log_time;
   logic next_adc_start, next_log_valid, next_log_event, take_event, take_timed;
   logic [1:0] next_adc_channel, next_log_source;
   logic [ADC_W-1:0] next_log_value;
   logic hit1, hit2, event_trig;

   always_comb
   begin
      hit1 = first_sensor_input && !in1_d && irq_src_sel[0];
      hit2 = second_sensor_input && !in2_d && irq_src_sel[1];
      event_trig = event_mode && rtc_running && (hit1 || hit2);
      next_state = state;
      next_mask = mask;
      next_log_time = log_wr_time;
      next_adc_start = 1'b0;
      next_adc_channel = adc_channel;
      next_log_valid = log_wr_valid;
      next_log_value = log_wr_value;
      next_log_event = log_wr_event;
      next_log_source = log_wr_source;
      take_event = 1'b0;
      take_timed = 1'b0;
      rest = mask & ~(NUM_CH'(1) << adc_channel);
      case (state)
         ST_IDLE:
         begin
            if (rtc_running)
            begin
               next_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE:
         begin
            // Events first; a timed trigger waits in its pending flag
            take_event = pend_event;
            take_timed = !pend_event && pend_timed;
            next_mask = pend_event ? irq_meas_sel : timed_meas_sel;
            if ((take_event || take_timed) && next_mask != '0)
            begin
               next_log_time = rtc_time;
               next_log_event = take_event;
               next_log_source = take_event ? pend_src : 2'h0;
               next_adc_channel = first_chan(next_mask);
               next_adc_start = 1'b1;
               next_state = ST_CONV;
            end
         end
         ST_CONV:
         begin
            if (adc_done)
            begin
               next_log_value = adc_data;
               next_log_valid = 1'b1;
               next_state = ST_WRITE;
            end
         end
         ST_WRITE:
         begin
            if (log_wr_ready)
            begin
               next_log_valid = 1'b0;
               next_mask = rest;
               if (rest != '0)
               begin
                  next_adc_channel = first_chan(rest);
                  next_adc_start = 1'b1;
                  next_state = ST_CONV;
               end
               else
               begin
                  next_state = ST_ACTIVE;
               end
            end
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
      if (stop_cmd)
      begin
         next_state = ST_IDLE;
         next_log_valid = 1'b0;
         next_adc_start = 1'b0;
      end
      // Set beats clear so a trigger landing on the take is kept
      next_pend_timed = ((pend_timed && !take_timed) || timed_trig) && !stop_cmd;
      next_pend_event = ((pend_event && !take_event) || event_trig) && !stop_cmd;
      next_pend_src = pend_src;
      if (event_trig)
      begin
         next_pend_src = hit1 ? SEL_FIRST : SEL_SECOND;
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         state <= ST_IDLE;
         in1_d <= 1'b0;
         in2_d <= 1'b0;
         pend_timed <= 1'b0;
         pend_event <= 1'b0;
         pend_src <= 2'h0;
         mask <= '0;
         adc_start <= 1'b0;
         adc_channel <= CH_TEMP;
         log_wr_valid <= 1'b0;
         log_wr_value <= '0;
         log_wr_time <= '0;
         log_wr_event <= 1'b0;
         log_wr_source <= 2'h0;
      end
      else
      begin
         state <= next_state;
         in1_d <= first_sensor_input;
         in2_d <= second_sensor_input;
         pend_timed <= next_pend_timed;
         pend_event <= next_pend_event;
         pend_src <= next_pend_src;
         mask <= next_mask;
         adc_start <= next_adc_start;
         adc_channel <= next_adc_channel;
         log_wr_valid <= next_log_valid;
         log_wr_value <= next_log_value;
         log_wr_time <= next_log_time;
         log_wr_event <= next_log_event;
         log_wr_source <= next_log_source;
      end
   end

   assign log_wr_channel = adc_channel;
   assign adc_ref = ref_cfg[2*adc_channel +: 2];
   assign logging_busy = (state == ST_CONV) || (state == ST_WRITE);

   // Battery, supply, shelf life, front end range, link rates, passwords
   logic bat_chk, next_bat_chk, next_bat_is_3v, next_field, next_alarm, next_thr;
   logic next_fwd_ok, next_rtn_ok, warm, ext_done;
   logic [31:0] next_shelf, step;
   logic [ADC_W-1:0] last_temp, next_last_temp;
   logic [1:0] next_range;
   logic [PWD_W-1:0] pwd [NUM_AREAS];
   logic [PWD_W-1:0] next_pwd [NUM_AREAS];

   always_comb
   begin
      // Check again on retrigger once voltage has settled
      next_bat_chk = bat_check_retrigger;
      next_bat_is_3v = bat_chk ? bat_level_high : bat_is_3v;
      next_field = !bat_present || bat_drained;
      ext_done = adc_done && state == ST_CONV && (adc_channel == CH_FIRST_SENSOR_INPUT || adc_channel == CH_SECOND_SENSOR_INPUT);
      next_last_temp = (adc_done && state == ST_CONV && adc_channel == CH_TEMP) ? adc_data : last_temp;
      warm = last_temp > shelf_ref_temp;
      step = warm ? SHELF_STEP_WARM : SHELF_STEP_COOL;
      next_shelf = shelf_remaining;
      if (shelf_load)
      begin
         next_shelf = shelf_life_init;
      end
      else if (rtc_running && tick && shelf_remaining != '0)
      begin
         next_shelf = (shelf_remaining > step) ? shelf_remaining - step : '0;
      end
      next_alarm = (shelf_alarm || (shelf_remaining != '0 && next_shelf == '0)) && !shelf_load;
      next_range = ext_range;
      if (ext_done && adc_data >= RANGE_HI && ext_range != RANGE_TOP)
      begin
         next_range = ext_range + 1'b1;
      end
      else if (ext_done && adc_data <= RANGE_LO && ext_range != RANGE_RESET)
      begin
         next_range = ext_range - 1'b1;
      end
      next_thr = ext_done && adc_data > ext_thresh;
      next_fwd_ok = fwd_rate_kbps >= FWD_MIN_KBPS && fwd_rate_kbps <= FWD_MAX_KBPS;
      next_rtn_ok = rtn_rate_kbps >= RTN_MIN_KBPS && rtn_rate_kbps <= RTN_MAX_KBPS;
      for (int i = 0; i < NUM_AREAS; i++)
      begin
         next_pwd[i] = (pwd_load && pwd_load_area == 2'(i)) ? pwd_load_value : pwd[i];
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         bat_chk <= 1'b1;
         bat_is_3v <= 1'b0;
         supply_from_field <= 1'b0;
         shelf_remaining <= '0;
         shelf_alarm <= 1'b0;
         last_temp <= '0;
         ext_range <= RANGE_RESET;
         ext_thresh_hit <= 1'b0;
         fwd_rate_ok <= 1'b0;
         rtn_rate_ok <= 1'b0;
         for (int i = 0; i < NUM_AREAS; i++)
         begin
            pwd[i] <= '0;
         end
      end
      else
      begin
         bat_chk <= next_bat_chk;
         bat_is_3v <= next_bat_is_3v;
         supply_from_field <= next_field;
         shelf_remaining <= next_shelf;
         shelf_alarm <= next_alarm;
         last_temp <= next_last_temp;
         ext_range <= next_range;
         ext_thresh_hit <= next_thr;
         fwd_rate_ok <= next_fwd_ok;
         rtn_rate_ok <= next_rtn_ok;
         pwd <= next_pwd;
      end
   end

   stl_access_check u_access
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .acc_bank(acc_bank),
      .acc_area(acc_area),
      .acc_write(acc_write),
      .acc_spi(acc_spi),
      .acc_custom(acc_custom),
      .acc_pwd(acc_pwd),
      .pwd_table({pwd[2], pwd[1], pwd[0]}),
      .acc_grant(acc_grant)
   );

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   a_start_loads_rtc: assert property (start_cmd && !stop_cmd |=> rtc_running && rtc_time == $past(start_time))
      else $error("start-log did not load clock");
   a_rtc_held: assert property (!rtc_running && !start_cmd |=> !rtc_running)
      else $error("clock ran without start-log");
   a_rtc_steps: assert property (rtc_running && tick && !start_cmd && !stop_cmd |=> rtc_time == $past(rtc_time) + 32'h00000001)
      else $error("clock did not step on tick");
   a_interval_due: assert property (timed_trig |-> tick && !event_mode && sec_cnt == ivl - 16'h0001)
      else $error("timed trigger off interval");
   a_adc_pulse: assert property (adc_start |=> !adc_start && (state == ST_CONV || state == ST_IDLE))
      else $error("converter start not a pulse");
   a_first_wins: assert property (event_trig && hit1 && hit2 |=> pend_src == SEL_FIRST)
      else $error("second input won over first");
   a_entry_held: assert property (log_wr_valid && !log_wr_ready && !stop_cmd |=> log_wr_valid && $stable(log_wr_time) && $stable(log_wr_value))
      else $error("log entry changed before taken");
   a_back_active: assert property (state == ST_WRITE && log_wr_ready && rest == '0 && !stop_cmd |=> state == ST_ACTIVE && rtc_running)
      else $error("no return to active after log");
   a_both_kept: assert property (timed_trig && event_trig && !stop_cmd |=> pend_timed && pend_event)
      else $error("simultaneous trigger dropped");
   a_alarm_expiry: assert property (shelf_alarm |-> shelf_remaining == 32'h00000000)
      else $error("shelf alarm before expiry");
   a_field_supply: assert property (bat_present && !bat_drained |=> !supply_from_field)
      else $error("field supply with good battery");

   c_timed_log: cover property (state == ST_WRITE && log_wr_ready && !log_wr_event);
   c_event_log: cover property (state == ST_WRITE && log_wr_ready && log_wr_event);
   c_both_triggers: cover property (timed_trig && event_trig);
   c_shelf_alarm: cover property ($rose(shelf_alarm));
endmodule

// ===== stl_adc_model.sv
`timescale 1ns/1ps
module stl_adc_model
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic adc_start,
   input wire logic [1:0] adc_channel,
   input wire logic log_wr_valid,
   output logic adc_done,
   output logic [9:0] adc_data,
   output logic log_wr_ready
);
   // Result encodes the channel; the inverse shows between results
   initial
   begin
      adc_done = 0;
      adc_data = 10'h3FF;
      log_wr_ready = 0;
      forever
      begin
         @(posedge clk_sys);
         log_wr_ready <= log_wr_valid && !reset && ($urandom % 2);
         if (adc_start && !reset)
         begin
            repeat ($urandom % 3) @(posedge clk_sys);
            adc_done <= 1;
            adc_data <= {adc_channel, 8'h5A};
            @(posedge clk_sys);
            adc_done <= 0;
            adc_data <= ~{adc_channel, 8'h5A};
         end
      end
   end
endmodule

// ===== sensor_tag_logging_core_bench.sv
`timescale 1ns/1ps
module sensor_tag_logging_core_bench;
   import stl_pkg::*;
   logic clk_sys = 0, reset = 1, rf_start_log = 0, spi_start_log = 0, rf_stop_log = 0;
   logic spi_stop_log = 0, event_mode = 0, first_sensor_input = 0, second_sensor_input = 0;
   logic bat_check_retrigger = 0, bat_level_high = 1, bat_present = 1, bat_drained = 0;
   logic shelf_load = 0, pwd_load = 0, acc_write = 0, acc_spi = 0, acc_custom = 0;
   logic [1:0] irq_src_sel = 0, pwd_load_area = AREA_APP, acc_area = AREA_APP;
   logic [2:0] acc_bank = 0;
   logic [3:0] irq_meas_sel = 4'h2, timed_meas_sel = 4'h5;
   logic [7:0] ref_cfg = 0;
   logic [9:0] ext_thresh = 10'h200, shelf_ref_temp = 10'h3FF, fwd_rate_kbps = 0, rtn_rate_kbps = 0;
   logic [15:0] interval_sec = 16'h0001;
   logic [31:0] start_time = 0, shelf_life_init = 0, pwd_load_value = 0, acc_pwd = 0, t0, pw;
   logic adc_start, adc_done, ext_thresh_hit, log_wr_valid, log_wr_ready, log_wr_event;
   logic rtc_running, logging_busy, bat_is_3v, supply_from_field, shelf_alarm;
   logic fwd_rate_ok, rtn_rate_ok, acc_grant;
   logic [1:0] adc_channel, adc_ref, ext_range, log_wr_channel, log_wr_source;
   logic [9:0] adc_data, log_wr_value;
   logic [31:0] log_wr_time, rtc_time, shelf_remaining;
   int err_count = 0, checks = 0;
   always #25 clk_sys = ~clk_sys;
   // Short second keeps the run small; all expectations assume 20
   stl_core #(.TICK_CYCLES(20)) dut_u (.*);
   stl_adc_model adc_u (.*);
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input bit ok, input string m);
      checks++;
      if (!ok)
      begin
         err_count++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic start_clk(input bit from_rf);
      {rf_start_log, spi_start_log} = {from_rf, !from_rf};
      cyc(1);
      {rf_start_log, spi_start_log} = 2'h0;
   endtask
   task automatic entry(input logic [1:0] ch, input logic ev, input logic [1:0] src);
      int n;
      bit th;
      n = 0;
      th = 0;
      while (!(log_wr_valid === 1 && log_wr_ready === 1))
      begin
         cyc(1);
         th |= ext_thresh_hit === 1;
         n++;
         if (n > 600)
         begin
            chk(0, "no log entry");
            conclude();
         end
      end
      chk(log_wr_channel === ch && log_wr_value === {ch, 8'h5A} && log_wr_event === ev
         && log_wr_source === src && log_wr_time === t0 + 32'(!ev), "log entry");
      chk(adc_ref === ref_cfg[2*ch +: 2] && logging_busy === 1 && ext_range === RANGE_RESET, "front");
      chk(th === ((ch == CH_FIRST_SENSOR_INPUT || ch == CH_SECOND_SENSOR_INPUT) && {ch, 8'h5A} > ext_thresh), "threshold");
      cyc(1);
   endtask
   function automatic bit grant_exp();
      if (acc_bank == BANK_TAGID && acc_write)
         return 0;
      if (acc_spi || acc_bank == BANK_RESERVED || acc_bank == BANK_IDENT || acc_bank == BANK_TAGID)
         return 1;
      if (acc_bank == BANK_SYSTEM)
         return acc_custom;
      return acc_pwd[31:16] == pw[31:16] && (!acc_write || acc_pwd[15:0] == pw[15:0]);
   endfunction
   initial
   begin
      void'($urandom(24917));
      ref_cfg = 8'($urandom);
      cyc(2);
      reset = 0;
      cyc(1);
      chk(rtc_running === 0 && bat_is_3v === 1, "after reset");
      bat_level_high = 0;
      bat_check_retrigger = 1;
      cyc(1);
      bat_check_retrigger = 0;
      cyc(2);
      chk(bat_is_3v === 0, "battery recheck");
      for (int i = 0; i < 4; i++)
      begin
         {bat_present, bat_drained} = 2'(i);
         fwd_rate_kbps = i[1] ? FWD_MAX_KBPS + 10'(i[0]) : FWD_MIN_KBPS - 10'(!i[0]);
         rtn_rate_kbps = i[1] ? RTN_MAX_KBPS + 10'(i[0]) : RTN_MIN_KBPS - 10'(!i[0]);
         cyc(2);
         chk(supply_from_field === (!bat_present || bat_drained), "supply");
         chk(fwd_rate_ok === (i[1] ^ i[0]) && rtn_rate_ok === (i[1] ^ i[0]), "rate");
      end
      $display("test power and rates done");
      t0 = $urandom;
      start_time = t0;
      start_clk(0);
      chk(rtc_running === 1 && rtc_time === t0, "clock start");
      cyc(19);
      chk(rtc_time === t0, "clock early step");
      cyc(1);
      chk(rtc_time === t0 + 1, "clock step");
      entry(CH_TEMP, 0, 2'h0);
      entry(CH_SECOND_SENSOR_INPUT, 0, 2'h0);
      chk(rtc_running === 1, "clock after log");
      spi_stop_log = 1;
      cyc(1);
      spi_stop_log = 0;
      cyc(3);
      chk(rtc_running === 0 && log_wr_valid === 0, "stop");
      $display("test timed log done");
      event_mode = 1;
      irq_src_sel = SEL_BOTH;
      start_clk(1);
      {first_sensor_input, second_sensor_input} = 2'h3;
      entry(CH_FIRST_SENSOR_INPUT, 1, SEL_FIRST);
      {first_sensor_input, second_sensor_input} = 2'h0;
      start_clk(1);
      second_sensor_input = 1;
      entry(CH_FIRST_SENSOR_INPUT, 1, SEL_SECOND);
      $display("test event log done");
      // Clock still runs; two ticks fit in any 40 cycles, cool step applies
      shelf_life_init = 32'h00000002;
      shelf_load = 1;
      cyc(1);
      shelf_load = 0;
      chk(shelf_remaining === shelf_life_init && shelf_alarm === 0, "shelf load");
      cyc(40);
      chk(shelf_remaining === 0 && shelf_alarm === 1, "shelf expiry");
      $display("test shelf life done");
      pw = $urandom;
      pwd_load_value = pw;
      pwd_load = 1;
      cyc(1);
      pwd_load = 0;
      for (int i = 0; i < 40; i++)
      begin
         acc_bank = 3'($urandom % 5);
         {acc_write, acc_spi, acc_custom} = 3'($urandom);
         acc_pwd = pw ^ {($urandom % 2) ? 16'h0 : 16'h0001, ($urandom % 2) ? 16'h0 : 16'h8000};
         cyc(1);
         chk(acc_grant === grant_exp(), "access grant");
      end
      $display("test access done");
      conclude();
   end
endmodule
